// *** conv_host_model.sv ***
// Host-side partner: comparator answer and external start pulse train
`timescale 1ns/1ps
`default_nettype none

module conv_host_model #(
    parameter int SPACING = 32
) (
    // Clock and reset
    input  wire logic                                clk_i,
    input  wire logic                                rst_i,
    // Bench control
    input  wire logic [sar_seq_pkg::RES_BITS-1:0]    level_i,
    input  wire logic                                train_i,
    // Converter pins
    input  wire logic [sar_seq_pkg::RES_BITS-1:0]    trial_i,
    output logic                                     comp_o,
    output logic                                     start_n_o
);
    int cnt;

    // Comparator keeps the trial bit while the held input is at or above it
    assign comp_o = (level_i >= trial_i);

    // low pulses of 3 cycles, spaced wider than the bit clock
    // the pin idles high in reset so its release is not seen as a start edge
    always @(posedge clk_i) begin
        if (rst_i || !train_i) begin
            cnt       <= 0;
            start_n_o <= 1'b1;
        end else begin
            cnt       <= (cnt == SPACING - 1) ? 0 : cnt + 1;
            start_n_o <= !(cnt < 3);
        end
    end
endmodule // conv_host_model

`default_nettype wire

// *** sar_conversion_sequencer.sv ***
// Successive-approximation conversion sequencer with Wishbone register slave
//
// Notes on behaviour
// RULE1: Falling start edge resets the sequencer and begins a new conversion.
// RULE2: Status is high during reset and conversion, low once complete.
// RULE3: Twelve parallel result bits held stable until the next result.
// RULE4: Each bit decision goes out on the serial pin, NRZ, MSB first.
// RULE5: One bit per internal clock period, MSB downward, done after last bit.
// RULE6: Clock output gives 100 ns high pulses at 600 kHz or 1.5 MHz; the code gives 3-cycle (120 ns) pulses.
// RULE7: Short-cycle length ends the conversion after the last wanted bit.
// RULE8: Higher rate strap raises internal clock rate; 5V for 10, 15V for 8 bits.
// RULE9: Host must not run the clock beyond the resolution's maximum rate.
// RULE10: External clocking means a train of low pulses on the start pin.
// RULE11: External pulse rate stays below the configured internal rate.
// RULE12: Each external low pulse lasts 100 to 300 ns.
// RULE13: An N-bit externally clocked conversion takes N+1 pulses.
// RULE14: A continuous pulse train yields one N-bit result every N+1 pulses.
// RULE15: Host may gate the pulse train with status for single conversions.
// RULE16: Host waits for buffer settling before the falling start edge.
// RULE17: Unipolar coding is complementary binary.
// RULE18: Bipolar coding is complementary offset binary.
// RULE19: Two's complement option is offset binary with MSB inverted.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sar_conversion_sequencer #(
    parameter bit FAST_MODEL = 1'b0
) (
    // Clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    // Register bus
    input  wire sar_seq_pkg::wb_req_t               wb_i,
    output var   sar_seq_pkg::wb_rsp_t              wb_o,
    // Converter pins
    input  wire logic                               start_n_i,
    input  wire logic                               comp_i,
    output logic [sar_seq_pkg::RES_BITS-1:0]        trial_o,
    output logic [sar_seq_pkg::RES_BITS-1:0]        data_o,
    output logic                                    status_o,
    output logic                                    serial_o,
    output logic                                    clk_out_o,
    // Interrupt
    output logic                                    irq_o
);

    // Whole module state
    typedef struct packed {
        sar_seq_pkg::conv_state_t                st;
        logic [sar_seq_pkg::RES_BITS-1:0]        sar;
        logic [sar_seq_pkg::IDX_W-1:0]           idx;
        logic [sar_seq_pkg::DIV_W-1:0]           div;
        logic [sar_seq_pkg::PULSE_W-1:0]         pulse;
        logic                                    start_q;
        logic [sar_seq_pkg::RES_BITS-1:0]        result;
        logic                                    serial;
        logic                                    ext_mode;
        logic [1:0]                              rate;
        logic                                    twos;
        logic [3:0]                              len;
        logic [sar_seq_pkg::IRQ_N-1:0]           irq_stat;
        logic [sar_seq_pkg::IRQ_N-1:0]           irq_en;
        logic                                    irq;
        logic                                    ack;
        logic [31:0]                             rdat;
        logic                                    stat;
        logic                                    clk_pulse;
    } seq_state_t;

    seq_state_t r;
    seq_state_t n;

    // Decoded events, visible to the checks below
    logic                               busy;
    logic                               start_fall;
    logic                               bus_acc;
    logic                               wr_ctrl;
    logic                               sw_start;
    logic                               begin_conv;
    logic                               tick;
    logic                               finish;
    logic [sar_seq_pkg::IDX_W-1:0]      last_idx;
    logic [sar_seq_pkg::DIV_W-1:0]      period;
    logic [sar_seq_pkg::RES_BITS-1:0]   sar_done;
    logic [sar_seq_pkg::RES_BITS-1:0]   code;
    logic [sar_seq_pkg::IRQ_N-1:0]      irq_set;
    logic [sar_seq_pkg::IRQ_N-1:0]      irq_clr;

    // Next-state logic
    always_comb begin
        n          = r;
        n.ack      = 1'b0;
        n.start_q  = start_n_i;
        irq_set    = '0;
        irq_clr    = '0;
        busy       = (r.st != sar_seq_pkg::ST_IDLE);
        start_fall = r.start_q & ~start_n_i;
        period     = sar_seq_pkg::period_cyc(FAST_MODEL, r.rate);

        // RULE7 short-cycle end; lengths outside 1..12 mean full resolution
        if ((r.len == 4'h0) || (r.len > sar_seq_pkg::LEN_FULL)) begin
            last_idx = '0;
        end else begin
            last_idx = sar_seq_pkg::LEN_FULL - r.len;
        end

        // Wishbone classic slave: one wait state, answer every address
        bus_acc  = wb_i.cyc & wb_i.stb & ~r.ack;
        wr_ctrl  = bus_acc & wb_i.we & (wb_i.adr == sar_seq_pkg::ADR_CTRL);
        sw_start = wr_ctrl & wb_i.sel[0] & wb_i.dat[sar_seq_pkg::CTRL_START];
        if (bus_acc) begin
            n.ack  = 1'b1;
            n.rdat = '0;
            if (wb_i.we) begin
                unique case (wb_i.adr)
                    sar_seq_pkg::ADR_CTRL: begin
                        if (wb_i.sel[0]) begin
                            n.ext_mode = wb_i.dat[sar_seq_pkg::CTRL_EXT];
                            n.rate     = wb_i.dat[sar_seq_pkg::CTRL_RATE +: 2];
                            n.twos     = wb_i.dat[sar_seq_pkg::CTRL_TWOS];
                        end
                        if (wb_i.sel[1]) begin
                            n.len = wb_i.dat[sar_seq_pkg::CTRL_LEN +: 4];
                        end
                    end
                    sar_seq_pkg::ADR_IRQ_CLR: begin
                        if (wb_i.sel[0]) begin
                            irq_clr = wb_i.dat[sar_seq_pkg::IRQ_N-1:0];
                        end
                    end
                    sar_seq_pkg::ADR_IRQ_EN: begin
                        if (wb_i.sel[0]) begin
                            n.irq_en = wb_i.dat[sar_seq_pkg::IRQ_N-1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (wb_i.adr)
                    sar_seq_pkg::ADR_CTRL: begin
                        n.rdat[sar_seq_pkg::CTRL_EXT]       = r.ext_mode;
                        n.rdat[sar_seq_pkg::CTRL_RATE +: 2] = r.rate;
                        n.rdat[sar_seq_pkg::CTRL_TWOS]      = r.twos;
                        n.rdat[sar_seq_pkg::CTRL_LEN +: 4]  = r.len;
                    end
                    sar_seq_pkg::ADR_STATUS: begin
                        n.rdat[0]                                   = busy;
                        n.rdat[sar_seq_pkg::STAT_IDX +: sar_seq_pkg::IDX_W] = r.idx;
                    end
                    sar_seq_pkg::ADR_RESULT: begin
                        n.rdat[sar_seq_pkg::RES_BITS-1:0] = r.result;
                    end
                    sar_seq_pkg::ADR_IRQ_STAT: begin
                        n.rdat[sar_seq_pkg::IRQ_N-1:0] = r.irq_stat;
                    end
                    sar_seq_pkg::ADR_IRQ_EN: begin
                        n.rdat[sar_seq_pkg::IRQ_N-1:0] = r.irq_en;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // RULE1 start edge; RULE14 in external mode an idle edge starts the next one
        begin_conv = sw_start | (start_fall & (~r.ext_mode | ~busy));

        // RULE8 internal divider at strap rate; RULE13 external edges are the ticks
        if (r.ext_mode) begin
            tick = start_fall & busy;
        end else begin
            tick = busy & (r.div == '0);
        end

        // Final decision and output coding of the completed word
        sar_done         = r.sar;
        sar_done[r.idx]  = comp_i;
        finish           = tick & ~begin_conv & (r.st == sar_seq_pkg::ST_CONV)
                           & (r.idx == last_idx);
        // RULE17 RULE18 complementary binary or offset binary
        code = ~sar_done;
        // RULE19 two's complement flips the MSB back
        if (r.twos) begin
            code[sar_seq_pkg::RES_BITS-1] = sar_done[sar_seq_pkg::RES_BITS-1];
        end

        // Clock-out pulse shrinks each cycle unless reloaded below
        if (r.pulse != '0) begin
            n.pulse = r.pulse - 1'b1;
        end

        // RULE2 status follows the state: reset phase and conversion are busy
        if (begin_conv) begin
            if (busy) begin
                irq_set[sar_seq_pkg::IRQ_RESTART] = 1'b1;
            end
            n.st  = sar_seq_pkg::ST_RST;
            n.sar = '0;
            n.idx = sar_seq_pkg::IDX_MSB;
            n.div = period - 1'b1;
            // RULE13 an external start pulse doubles as the first bit clock and places
            // the MSB trial; otherwise N bits would take N+2 pulses
            if (r.ext_mode) begin
                n.st    = sar_seq_pkg::ST_CONV;
                n.sar[sar_seq_pkg::IDX_MSB] = 1'b1;
                n.pulse = sar_seq_pkg::PULSE_CYC;
            end
        end else if (tick) begin
            // RULE6 one PULSE_CYC pulse (100 ns rounded up to 3 cycles, 120 ns) per bit period
            n.pulse = sar_seq_pkg::PULSE_CYC;
            n.div   = period - 1'b1;
            unique case (r.st)
                sar_seq_pkg::ST_RST: begin
                    // RULE5 first period places the MSB trial
                    n.sar      = '0;
                    n.sar[sar_seq_pkg::IDX_MSB] = 1'b1;
                    n.idx      = sar_seq_pkg::IDX_MSB;
                    n.st       = sar_seq_pkg::ST_CONV;
                end
                sar_seq_pkg::ST_CONV: begin
                    // RULE4 NRZ serial bit, complementary like the word
                    n.serial = ~comp_i;
                    n.sar    = sar_done;
                    if (finish) begin
                        // RULE3 result changes only at completion
                        n.result = code;
                        n.st     = sar_seq_pkg::ST_IDLE;
                        irq_set[sar_seq_pkg::IRQ_DONE] = 1'b1;
                    end else begin
                        // RULE5 next lower trial bit
                        n.idx        = r.idx - 1'b1;
                        n.sar[r.idx - 1'b1] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (busy && (r.div != '0)) begin
            n.div = r.div - 1'b1;
        end

        // Sticky events; a set in the clearing cycle wins
        n.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
        n.irq      = |(n.irq_stat & n.irq_en);

        // Pin copies registered so the outputs carry no decode glitches
        n.stat      = (n.st != sar_seq_pkg::ST_IDLE);
        n.clk_pulse = (n.pulse != '0);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r          <= '0;
            r.st       <= sar_seq_pkg::ST_IDLE;
            r.start_q  <= 1'b1;
            r.result   <= '1;
            r.len      <= sar_seq_pkg::LEN_FULL;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign wb_o      = '{ack: r.ack, dat: r.rdat};
    assign trial_o   = r.sar;
    assign data_o    = r.result;
    assign status_o  = r.stat;
    assign serial_o  = r.serial;
    assign clk_out_o = r.clk_pulse;
    assign irq_o     = r.irq;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_start_restarts: assert property (begin_conv && !r.ext_mode |=> status_o && trial_o == '0) // RULE1
        else $error("start edge did not reset the sequencer");

    a_done_drops_status: assert property (finish |=> !status_o ##1 !status_o || $past(begin_conv)) // RULE2
        else $error("status still high after completion");

    a_result_stable: assert property ($changed(data_o) |-> $fell(status_o)) // RULE3
        else $error("result changed outside completion");

    a_serial_decision: assert property (tick && r.st == sar_seq_pkg::ST_CONV && !begin_conv
                                        |=> serial_o == !$past(comp_i)) // RULE4
        else $error("serial bit differs from decision");

    a_msb_first: assert property (tick && r.st == sar_seq_pkg::ST_RST && !begin_conv
                                  |=> trial_o == 12'h800) // RULE5
        else $error("conversion did not start at MSB");

    a_clk_pulse: assert property ($rose(clk_out_o) |-> clk_out_o[*3] ##1 !clk_out_o) // RULE6
        else $error("clock-out pulse width wrong");

    a_short_end: assert property ($fell(status_o) |-> r.idx == last_idx) // RULE7
        else $error("conversion ended at wrong bit");

    a_coding_plain: assert property ($changed(data_o) && !r.twos |-> data_o == ~trial_o) // RULE17
        else $error("complementary coding wrong");

    a_coding_twos: assert property ($changed(data_o) && r.twos
                                    |-> data_o == {trial_o[11], ~trial_o[10:0]}) // RULE19
        else $error("two's complement coding wrong");

    a_ext_tick_only: assert property (r.ext_mode && $changed(r.idx) && r.st == sar_seq_pkg::ST_CONV
                                      |-> $past(start_fall)) // RULE13
        else $error("external mode advanced without a start edge");

    a_ext_begin_msb: assert property (begin_conv && r.ext_mode // RULE13
                                      |=> status_o && trial_o == 12'h800)
        else $error("external start did not place the MSB trial");

    a_serial_at_tick: assert property ($changed(serial_o) |-> $past(tick)) // RULE4
        else $error("serial bit changed between decisions");

    a_trial_idle_hold: assert property (!status_o && !$past(status_o) |-> $stable(trial_o)) // RULE5
        else $error("trial word moved while idle");

    a_pulse_at_tick: assert property ($rose(clk_out_o) |-> $past(tick || begin_conv)) // RULE6
        else $error("clock-out pulse without a bit period");

    a_done_flag_set: assert property (finish |=> r.irq_stat[sar_seq_pkg::IRQ_DONE]) // RULE5
        else $error("completion did not set its flag");

    a_restart_flag_set: assert property (begin_conv && busy // RULE1
                                         |=> r.irq_stat[sar_seq_pkg::IRQ_RESTART])
        else $error("restart did not set its flag");

    // Bus contract: one answer per request, read data stands until the next access
    a_ack_follows_req: assert property (bus_acc |=> wb_o.ack)
        else $error("bus request not acknowledged");

    a_ack_one_cycle: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("acknowledge held too long");

    a_read_data_hold: assert property (!$past(bus_acc) |-> $stable(wb_o.dat))
        else $error("read data changed without an access");

endmodule // sar_conversion_sequencer

`default_nettype wire

// *** sar_conversion_sequencer_tb.sv ***
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module sar_conversion_sequencer_tb;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    sar_seq_pkg::wb_req_t wb_i  = '0;
    sar_seq_pkg::wb_rsp_t wb_o;
    logic [11:0]          trial_o, data_o, ser, last_exp;
    logic [11:0]          level = 12'h000;
    logic                 status_o, serial_o, clk_out_o, irq_o, comp, start_n;
    logic                 train = 1'b0;
    logic                 co_q = 1'b0, sn_q = 1'b1, st_q = 1'b0;
    logic [31:0]          rd;
    int                   n_errors = 0, tests_run = 0, cyc = 0, ticks = 0, gap = 0;
    int                   last_t = 0, wid = 0, nfall = 0, done_n = 0;
    int                   fa [2];
    // Coding table: input level, two's option, rate strap, length
    logic [11:0]          lv [4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
    logic                 tw [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [1:0]           rt [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
    logic [3:0]           ln [4] = '{4'hc, 4'ha, 4'hc, 4'h8};

    // 25 MHz system clock
    always #20 clk_i = ~clk_i;

    sar_conversion_sequencer #(.FAST_MODEL(1'b0)) sar_conversion_sequencer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .start_n_i(start_n),
        .comp_i(comp), .trial_o(trial_o), .data_o(data_o), .status_o(status_o),
        .serial_o(serial_o), .clk_out_o(clk_out_o), .irq_o(irq_o));

    conv_host_model #(.SPACING(32)) conv_host_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .level_i(level), .train_i(train),
        .trial_i(trial_o), .comp_o(comp), .start_n_o(start_n));

    task automatic test_done();
        $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Classic single cycle; read data and write effect belong to the ack edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
        @(posedge clk_i);
        while (wb_o.ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20) chk(0, 1, "bus ack timeout");
        rd = wb_o.dat;
        wb_i <= '0;
    endtask

    task automatic wait_st(input logic v);
        int n;
        n = 0;
        while (status_o !== v && n < 2000) begin
            n++;
            @(posedge clk_i);
        end
        chk(32'(status_o), 32'(v), "status level");
    endtask

    // One internal-clock conversion, optionally restarted midway
    task automatic run_conv(input logic [11:0] lvl, input logic twos, input logic [1:0] rate,
                            input logic [3:0] len, input logic rs);
        logic [31:0] cfg;
        logic [11:0] sar, exp;
        int          khz;
        cfg = {20'h0, len, 3'h0, twos, rate, 2'h0};
        sar = lvl & ~(12'hfff >> len);
        exp = twos ? {sar[11], ~sar[10:0]} : ~sar;
        khz = (rate == 2'h0) ? sar_seq_pkg::RATE_SLOW_0_KHZ :
              (rate == 2'h1) ? sar_seq_pkg::RATE_SLOW_5_KHZ : sar_seq_pkg::RATE_SLOW_15_KHZ;
        level <= lvl;
        wb_xfer(1'b1, sar_seq_pkg::ADR_CTRL, cfg);
        ticks = 0;
        wb_xfer(1'b1, sar_seq_pkg::ADR_CTRL, cfg | 32'h1);
        wait_st(1'b1);
        if (rs) begin
            repeat (200) @(posedge clk_i);
            wb_xfer(1'b1, sar_seq_pkg::ADR_CTRL, cfg | 32'h1);
            ticks = 0;
            chk(status_o, 1, "busy after restart");
            chk(data_o, last_exp, "result held");
            wb_xfer(1'b0, sar_seq_pkg::ADR_STATUS, 32'h0);
            chk(rd, 32'h0000_0b01, "status register");
        end
        wait_st(1'b0);
        chk(data_o, exp, "coded result");
        repeat (4) @(posedge clk_i);
        chk(ticks, len + 1, "bit ticks");
        chk(gap, (sar_seq_pkg::CLK_KHZ + khz - 1) / khz, "bit period");
        if (len == 4'hc) chk(ser, 12'(~lvl), "serial stream");
        wb_xfer(1'b0, sar_seq_pkg::ADR_RESULT, 32'h0);
        chk(rd, {20'h0, exp}, "result register");
        last_exp = exp;
    endtask

    // Monitor of bit clock, serial line, start pulses and completions
    always @(posedge clk_i) begin
        cyc++;
        if (clk_out_o && !co_q) begin
            ticks++;
            gap    = cyc - last_t;
            last_t = cyc;
        end
        if (!clk_out_o && co_q) begin
            // pulse width, 100 ns rounded up to whole cycles
            chk(wid, (sar_seq_pkg::PULSE_NS + sar_seq_pkg::CLK_NS - 1) / sar_seq_pkg::CLK_NS, "pulse");
            ser = {ser[10:0], serial_o};
        end
        wid = clk_out_o ? wid + 1 : 0;
        if (!start_n && sn_q) nfall++;
        if (!status_o && st_q) begin
            if (done_n < 2) fa[done_n] = nfall;
            done_n++;
        end
        co_q = clk_out_o;
        sn_q = start_n;
        st_q = status_o;
        // Whole run needs under 10000 cycles; a hang ends here
        if (cyc == 30000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        int n;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(data_o, 12'hfff, "reset result");
        chk(status_o, 0, "reset status");
        wb_xfer(1'b0, sar_seq_pkg::ADR_CTRL, 32'h0);
        chk(rd, 32'h0000_0c00, "ctrl reset");
        wb_xfer(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        wb_xfer(1'b1, sar_seq_pkg::ADR_IRQ_EN, 32'h1);
        wb_xfer(1'b0, sar_seq_pkg::ADR_IRQ_EN, 32'h0);
        chk(rd, 32'h1, "irq enable");
        last_exp = 12'hfff;
        run_conv(12'h5a3, 1'b0, 2'h0, 4'hc, 1'b0);
        chk(irq_o, 1, "irq raised");
        wb_xfer(1'b0, sar_seq_pkg::ADR_IRQ_STAT, 32'h0);
        chk(rd & 32'h3, 32'h1, "done flag");
        wb_xfer(1'b1, sar_seq_pkg::ADR_IRQ_CLR, 32'h1);
        wb_xfer(1'b1, sar_seq_pkg::ADR_IRQ_EN, 32'h0);
        chk(irq_o, 0, "irq cleared");
        for (int i = 0; i < 4; i++) run_conv(lv[i], tw[i], rt[i], ln[i], 1'b0);
        chk(irq_o, 0, "irq masked");
        run_conv(12'h3c5, 1'b0, 2'h0, 4'hc, 1'b1);
        wb_xfer(1'b0, sar_seq_pkg::ADR_IRQ_STAT, 32'h0);
        chk(rd & 32'h2, 32'h2, "restart flag");
        // External clocking on the start pin, 8-bit length, fastest strap
        wb_xfer(1'b1, sar_seq_pkg::ADR_CTRL, 32'h0000_080a);
        level <= 12'h9b6;
        // input settles before the first falling edge
        repeat (5) @(posedge clk_i);
        nfall  = 0;
        done_n = 0;
        train <= 1'b1;
        n = 0;
        while (done_n < 2 && n < 3000) begin
            n++;
            @(posedge clk_i);
        end
        chk(fa[0], 9, "pulses for first result");
        chk(fa[1], 18, "pulses for second result");
        chk(data_o, 12'h64f, "external result");
        train <= 1'b0;
        // Single conversion: the train is cut as soon as status falls
        level <= 12'h3c8;
        repeat (40) @(posedge clk_i);
        nfall  = 0;
        done_n = 0;
        train <= 1'b1;
        n = 0;
        while (done_n < 1 && n < 3000) begin
            n++;
            @(posedge clk_i);
        end
        train <= 1'b0;
        repeat (80) @(posedge clk_i);
        chk(nfall, 9, "pulses of gated run");
        chk(status_o, 0, "idle after gated run");
        chk(data_o, 12'hc3f, "gated result");
        test_done();
    end
endmodule // sar_conversion_sequencer_tb

`default_nettype wire

// *** sar_seq_pkg.sv ***
// Constants, types and register map of the successive-approximation sequencer
package sar_seq_pkg;

    // Result width and conversion geometry
    localparam int RES_BITS = 12;
    localparam int IDX_W    = 4;
    localparam logic [IDX_W-1:0] IDX_MSB = 4'hb;
    localparam logic [3:0]       LEN_FULL = 4'hc;

    // System clock
    localparam int CLK_NS  = 40;
    localparam int CLK_KHZ = 25000;

    // Clock-out pulse width, rounded up to whole cycles
    localparam int PULSE_NS  = 100;
    localparam int PULSE_W   = 2;
    localparam logic [PULSE_W-1:0] PULSE_CYC = PULSE_W'((PULSE_NS + CLK_NS - 1) / CLK_NS);

    // Internal bit-clock rates per rate strap, slow and fast model
    localparam int RATE_SLOW_0_KHZ = 600;
    localparam int RATE_SLOW_5_KHZ = 720;
    localparam int RATE_SLOW_15_KHZ = 880;
    localparam int RATE_FAST_0_KHZ = 1500;
    localparam int RATE_FAST_5_KHZ = 1800;
    localparam int RATE_FAST_15_KHZ = 2200;
    localparam int DIV_W = 6;

    // Rate strap codes
    localparam logic [1:0] RATE_0V  = 2'h0;
    localparam logic [1:0] RATE_5V  = 2'h1;

    // Register byte offsets
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] ADR_CTRL     = 8'h00;
    localparam logic [ADR_W-1:0] ADR_STATUS   = 8'h04;
    localparam logic [ADR_W-1:0] ADR_RESULT   = 8'h08;
    localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 8'h0c;
    localparam logic [ADR_W-1:0] ADR_IRQ_CLR  = 8'h10;
    localparam logic [ADR_W-1:0] ADR_IRQ_EN   = 8'h14;

    // Control and status field positions
    localparam int CTRL_START  = 0;
    localparam int CTRL_EXT    = 1;
    localparam int CTRL_RATE   = 2;
    localparam int CTRL_TWOS   = 4;
    localparam int CTRL_LEN    = 8;
    localparam int STAT_IDX    = 8;

    // Interrupt bits
    localparam int IRQ_N       = 2;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_RESTART = 1;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RST  = 3'b010,
        ST_CONV = 3'b100
    } conv_state_t;

    // Classic Wishbone request and answer
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [3:0]       sel;
        logic [31:0]      dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Bit-clock period in system cycles, rounded up so the rate never exceeds the figure
    function automatic logic [DIV_W-1:0] period_cyc(input logic fast, input logic [1:0] rate);
        int khz;
        if (rate == RATE_0V) begin
            khz = fast ? RATE_FAST_0_KHZ : RATE_SLOW_0_KHZ;
        end else if (rate == RATE_5V) begin
            khz = fast ? RATE_FAST_5_KHZ : RATE_SLOW_5_KHZ;
        end else begin
            khz = fast ? RATE_FAST_15_KHZ : RATE_SLOW_15_KHZ;
        end
        return DIV_W'((CLK_KHZ + khz - 1) / khz);
    endfunction

endpackage
